// ===== strap_option_latch.sv
// Register access over APB and the register offsets were left to the implementer.
`default_nettype none

module strap_option_latch
  import strap_option_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        endian_strap_pin_in,
  output logic             endian_strap_pin_out,
  output logic             endian_strap_pin_oe_n,
  input  wire logic        bus_width_strap_pin_in,
  output logic             bus_width_strap_pin_out,
  output logic             bus_width_strap_pin_oe_n,
  input  wire logic        config_memory_enable_strap,
  input  wire logic        bus_variant_32,
  input  wire logic        endian_pin_func_data,
  input  wire logic        bus_width_pin_func_data,
  output logic             big_endian_mode,
  output logic             bus_width_16,
  output logic             straps_valid
);

  localparam int SETTLE_MAX = SETTLE_CYCLES + 2;

  function automatic logic addr_mapped(input logic [11:0] a);
    return (a == ADDR_CCR) || (a == ADDR_RFPR);
  endfunction : addr_mapped

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [SYNC_W-1:0] pin_sync;
  logic              endian_sync;
  logic              width_sync;
  logic              cfg_mem_sync;
  logic              v32_sync;

  strap_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({bus_variant_32, config_memory_enable_strap,
                bus_width_strap_pin_in, endian_strap_pin_in}),
    .sync_out (pin_sync)
  );

  assign endian_sync  = pin_sync[0];
  assign width_sync   = pin_sync[1];
  assign cfg_mem_sync = pin_sync[2];
  assign v32_sync     = pin_sync[3];

  ////////////////////////////////////////////////////////////////////////////////
  // Sampling sequencer: settle, capture once, then run.

  strap_state_e     state;
  strap_state_e     next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    unique case (state)
      s_settle: begin
        if (cnt == CNT_W'(SETTLE_CYCLES - 1)) begin
          next_state = s_capture;
          next_cnt   = CNT_ZERO;
        end else begin
          next_cnt = cnt + CNT_ONE;
        end
      end
      s_capture: begin
        next_state = s_run;
      end
      s_run: begin
        next_state = s_run;
      end
      default: begin
        next_state = s_settle;
        next_cnt   = CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= s_settle;
      cnt   <= CNT_ZERO;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strap latches; written only in the single capture cycle after reset.

  logic       ccr_endian;
  logic [1:0] ccr_width;
  logic       drive_pins;
  logic       next_ccr_endian;
  logic [1:0] next_ccr_width;
  logic       next_drive_pins;

  always_comb begin
    next_ccr_endian = ccr_endian;
    next_ccr_width  = ccr_width;
    next_drive_pins = drive_pins;
    if (state == s_capture) begin
      next_ccr_endian = endian_sync;
      next_drive_pins = 1'b1;
      if (v32_sync) begin
        next_ccr_width = WIDTH_32;
      end else if (!cfg_mem_sync) begin
        next_ccr_width = width_sync ? WIDTH_16 : WIDTH_8;
      end else begin
        // Width comes from the configuration memory; keep the default here.
        next_ccr_width = WIDTH_RESET;
      end
    end
  end

  // Nothing but reset can reach the capture state again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccr_endian <= ENDIAN_RESET;
      ccr_width  <= WIDTH_RESET;
      drive_pins <= 1'b0;
    end else begin
      ccr_endian <= next_ccr_endian;
      ccr_width  <= next_ccr_width;
      drive_pins <= next_drive_pins;
    end
  end

  // Pins float as inputs until capture, then carry their normal function.
  assign endian_strap_pin_oe_n    = ~drive_pins;
  assign bus_width_strap_pin_oe_n = ~drive_pins;
  assign endian_strap_pin_out     = drive_pins & endian_pin_func_data;
  assign bus_width_strap_pin_out  = drive_pins & bus_width_pin_func_data;

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave with zero wait states.

  logic        sw_endian;
  logic        next_sw_endian;
  logic [31:0] next_prdata;
  logic        wr_rfpr;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);
  assign wr_rfpr = psel & penable & pwrite & (paddr == ADDR_RFPR) & pstrb[RFPR_ENDIAN_LANE];

  always_comb begin
    next_sw_endian = sw_endian;
    next_prdata    = prdata;
    if (wr_rfpr) begin
      next_sw_endian = pwdata[RFPR_ENDIAN_BIT];
    end
    // Read data is registered in the setup cycle and stands in the access cycle.
    if (psel && !penable && !pwrite) begin
      next_prdata = DATA_ZERO;
      if (paddr == ADDR_CCR) begin
        next_prdata[CCR_ENDIAN_BIT]             = ccr_endian;
        next_prdata[CCR_WIDTH_HI:CCR_WIDTH_LO]  = ccr_width;
        next_prdata[CCR_DONE_BIT]               = straps_valid;
      end else if (paddr == ADDR_RFPR) begin
        next_prdata[RFPR_ENDIAN_BIT] = sw_endian;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_endian <= ENDIAN_RESET;
      prdata    <= DATA_ZERO;
    end else begin
      sw_endian <= next_sw_endian;
      prdata    <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Effective configuration.

  assign straps_valid    = drive_pins;
  // A high strap forces big endian; software picks only when the strap is low.
  assign big_endian_mode = ccr_endian | sw_endian;
  assign bus_width_16    = (ccr_width == WIDTH_16);

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  // Read data is loaded at the setup edge, so readback checks compare it with the
  // register values of that edge; a capture in the same cycle must not trip them.

  endian_select_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (straps_valid && ccr_endian) |-> big_endian_mode)
    else $error("strapped big endian not applied");

  endian_capture_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == s_capture) |=> (ccr_endian == $past(endian_sync)))
    else $error("endian strap not captured into bit 10");

  soft_endian_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (straps_valid && !ccr_endian && wr_rfpr)
      |=> (big_endian_mode == $past(pwdata[RFPR_ENDIAN_BIT])))
    else $error("software endian bit not applied");

  width_select_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == s_capture && !v32_sync && !cfg_mem_sync)
      |=> (bus_width_16 == $past(width_sync)))
    else $error("bus width strap not applied");

  width_ignore_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == s_capture && v32_sync) |=> (ccr_width == WIDTH_32) && !bus_width_16)
    else $error("width strap not ignored in 32-bit variant");

  width_readback_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == ADDR_CCR)
      |=> (prdata[CCR_WIDTH_HI:CCR_WIDTH_LO] == $past(ccr_width)))
    else $error("width bits 7:6 read back wrong");

  pin_direction_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == s_settle) |-> endian_strap_pin_oe_n && bus_width_strap_pin_oe_n
      ##[1:SETTLE_MAX] !endian_strap_pin_oe_n && !bus_width_strap_pin_oe_n)
    else $error("strap pins not released to outputs in time");

  latch_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    straps_valid |=> $stable(ccr_endian) && $stable(ccr_width) && straps_valid)
    else $error("latched straps changed after capture");

  endian_readback_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == ADDR_CCR)
      |=> (prdata[CCR_ENDIAN_BIT] == $past(ccr_endian)))
    else $error("endian bit 10 read back wrong");

  soft_readback_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == ADDR_RFPR)
      |=> (prdata[RFPR_ENDIAN_BIT] == $past(sw_endian)))
    else $error("software endian bit 11 read back wrong");

  soft_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_rfpr |=> $stable(sw_endian))
    else $error("software endian bit changed without a write");

  width_default_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == s_capture && !v32_sync && !cfg_mem_sync && !width_sync)
      |=> (ccr_width == WIDTH_8) && !bus_width_16)
    else $error("low width strap did not give 8-bit bus");

  width_memory_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == s_capture && !v32_sync && cfg_mem_sync)
      |=> (ccr_width == WIDTH_RESET) && !bus_width_16)
    else $error("width strap used with configuration memory");

  straps_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == s_capture) |=> straps_valid && !endian_strap_pin_oe_n)
    else $error("strap pins not handed over after capture");

  pins_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !straps_valid |-> !endian_strap_pin_out && !bus_width_strap_pin_out)
    else $error("strap pin driven while still sampling");

  pins_drive_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    straps_valid |-> (endian_strap_pin_out == endian_pin_func_data)
      && (bus_width_strap_pin_out == bus_width_pin_func_data))
    else $error("strap pin not carrying its normal function");

  capture_once_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state == s_run) |=> (state == s_run))
    else $error("sequencer left the run state without reset");

endmodule : strap_option_latch

`default_nettype wire

// ===== strap_option_common.sv
`default_nettype none

package strap_option_pkg;

  // APB register map, byte addresses.
  localparam logic [11:0] ADDR_CCR  = 12'h000;
  localparam logic [11:0] ADDR_RFPR = 12'h004;

  // Field positions in the chip configuration register.
  localparam int CCR_DONE_BIT   = 0;
  localparam int CCR_WIDTH_LO   = 6;
  localparam int CCR_WIDTH_HI   = 7;
  localparam int CCR_ENDIAN_BIT = 10;

  // Field position in the receive frame pointer register.
  localparam int RFPR_ENDIAN_BIT = 11;
  localparam int RFPR_ENDIAN_LANE = 1;

  // Bus width codes held in bits 7:6.
  localparam logic [1:0] WIDTH_8  = 2'h1;
  localparam logic [1:0] WIDTH_16 = 2'h2;
  localparam logic [1:0] WIDTH_32 = 2'h0;

  // Reset values.
  localparam logic       ENDIAN_RESET = 1'h0;
  localparam logic [1:0] WIDTH_RESET  = WIDTH_8;
  localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

  // Pins settle under their pull resistors before the capture.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS     = 100;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;

  // Number of synchronised pin levels.
  localparam int SYNC_W = 4;

  typedef enum logic [1:0] {
    s_settle  = 2'b00,
    s_capture = 2'b01,
    s_run     = 2'b11
  } strap_state_e;

endpackage : strap_option_pkg

////////////////////////////////////////////////////////////////////////////////

module strap_sync
  import strap_option_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [SYNC_W-1:0] async_in,
  output var  logic [SYNC_W-1:0] sync_out
);

  logic [SYNC_W-1:0] stage1;
  logic [SYNC_W-1:0] next_stage1;
  logic [SYNC_W-1:0] next_sync_out;

  always_comb begin
    next_stage1   = async_in;
    next_sync_out = stage1;
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule : strap_sync

`default_nettype wire

// ===== board_straps.sv
`default_nettype none

module board_straps (
  input  wire logic endian_pull_up,
  input  wire logic width_pull_up,
  input  wire logic endian_oe_n,
  input  wire logic endian_drive,
  input  wire logic width_oe_n,
  input  wire logic width_drive,
  output logic      endian_level,
  output logic      width_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // A released pin settles to its resistor: the board pull-up if fitted, else the pull-down.
  assign endian_level = endian_oe_n ? endian_pull_up : endian_drive;
  assign width_level  = width_oe_n ? width_pull_up : width_drive;

endmodule : board_straps

`default_nettype wire

// ===== strap_option_latch_tb.sv
`default_nettype none

module strap_option_latch_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import strap_option_pkg::*;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        e_up, w_up, cm, v32, fe, fw, e_in, e_out, e_oen, w_in, w_out, w_oen;
  logic        big, w16, valid;
  int          fails = 0;
  int          n_checks = 0;

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  strap_option_latch uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .endian_strap_pin_in(e_in),
    .endian_strap_pin_out(e_out), .endian_strap_pin_oe_n(e_oen),
    .bus_width_strap_pin_in(w_in), .bus_width_strap_pin_out(w_out),
    .bus_width_strap_pin_oe_n(w_oen), .config_memory_enable_strap(cm),
    .bus_variant_32(v32), .endian_pin_func_data(fe), .bus_width_pin_func_data(fw),
    .big_endian_mode(big), .bus_width_16(w16), .straps_valid(valid));

  board_straps part (.endian_pull_up(e_up), .width_pull_up(w_up), .endian_oe_n(e_oen),
    .endian_drive(e_out), .width_oe_n(w_oen), .width_drive(w_out),
    .endian_level(e_in), .width_level(w_in));

  ////////////////////////////////////////////////////////////////////////////////

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] ccr_val(input logic e, input logic [1:0] wc);
    logic [31:0] v;
    v = DATA_ZERO;
    v[CCR_ENDIAN_BIT] = e;
    v[CCR_WIDTH_HI:CCR_WIDTH_LO] = wc;
    v[CCR_DONE_BIT] = 1'b1;
    return v;
  endfunction : ccr_val

  task run_case(input logic e, input logic w, input logic m, input logic v);
    logic [1:0] wc;
    int         i;
    wc = v ? WIDTH_32 : (m ? WIDTH_8 : (w ? WIDTH_16 : WIDTH_8));
    @(posedge pclk);
    presetn <= 1'b0;
    e_up <= e;
    w_up <= w;
    cm <= m;
    v32 <= v;
    fe <= !e;
    fw <= !w;
    repeat (4) @(posedge pclk);
    check(e_oen, 1);
    check(w_oen, 1);
    presetn <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (valid !== 1'b1 && i < 40);
    check(i, SETTLE_CYCLES + 2);
    // Every strap flips after capture; the latched values must not follow.
    e_up <= !e;
    w_up <= !w;
    cm <= !m;
    v32 <= !v;
    apb(1'b0, ADDR_CCR, DATA_ZERO, 4'h0);
    check(rd, ccr_val(e, wc));
    check(big, e);
    check(w16, wc == WIDTH_16);
    check(e_oen, 0);
    check(w_oen, 0);
    check(e_in, !e);
    check(w_in, !w);
    $display("strap case e=%0d w=%0d m=%0d v=%0d done", e, w, m, v);
  endtask : run_case

  task results;
    $display("comparisons %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////

  initial begin
    #50000;
    fails++;
    results;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = DATA_ZERO;
    pstrb = 4'h0;
    {e_up, w_up, cm, v32, fe, fw} = 6'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      run_case(k[0], k[1], k[2], k[3]);
    end
    run_case(1'b0, 1'b1, 1'b0, 1'b0);
    apb(1'b1, ADDR_RFPR, 32'h0000_0800, 4'h1);
    apb(1'b0, ADDR_RFPR, DATA_ZERO, 4'h0);
    check(rd, DATA_ZERO);
    check(big, 0);
    apb(1'b1, ADDR_RFPR, 32'h0000_0800, 4'h2);
    apb(1'b0, ADDR_RFPR, DATA_ZERO, 4'h0);
    check(rd, 32'h0000_0800);
    check(big, 1);
    apb(1'b1, ADDR_CCR, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, ADDR_CCR, DATA_ZERO, 4'h0);
    check(rd, ccr_val(1'b0, WIDTH_16));
    apb(1'b0, 12'h008, DATA_ZERO, 4'h0);
    check(err, 1);
    check(rd, DATA_ZERO);
    $display("software endian and access test done");
    results;
  end

endmodule : strap_option_latch_tb

`default_nettype wire
